// ### rtl/hpc_pkg.sv
// package: register map, field layout and reset values of the hub power config bank
`default_nettype none
package hpc_pkg;
	localparam logic [7:0] OFF_PORT_OFF_BP   = 8'h0b;
	localparam logic [7:0] OFF_DRAW_SP       = 8'h0c;
	localparam logic [7:0] OFF_DRAW_BP       = 8'h0d;
	localparam logic [7:0] OFF_CTRL_CUR_SP   = 8'h0e;
	localparam logic [7:0] OFF_PORT_OFF_SP   = 8'h0a;
	localparam logic [7:0] OFF_CFG_BYTE3     = 8'h08;
	localparam int         BIT_PORT1         = 1;
	localparam int         BIT_PORT2         = 2;
	localparam int         BIT_RSVD_ONE      = 3;
	localparam int         BIT_RSVD_ZERO     = 0;
	localparam int         BIT_REMAP_EN      = 3;
	localparam logic [7:0] MASK_FIXED_ONES   = 8'h08;
	localparam logic [7:0] MASK_WRITABLE     = 8'h06;
	localparam logic [7:0] RST_PORT_OFF      = 8'h08;
	localparam logic [7:0] RST_DRAW_SP       = 8'h01;
	localparam logic [7:0] RST_DRAW_BP       = 8'h32;
	localparam logic [7:0] RST_CTRL_CUR_SP   = 8'h32;
	localparam logic [7:0] RST_CFG_BYTE3     = 8'h00;
	localparam int         UNIT_MA           = 2;
endpackage
`default_nettype wire

// ### rtl/hpc_power_config.sv
// hub port-off mask and upstream power configuration bank with port renumbering
//
// Behaviour
// - bus-powered mask bit 1 disables its port
// - mask bit 3 reads one, bit 0 zero
// - masked ports never enabled without remapping
// - report active count, renumber active ports
// - default configuration takes mask from strap pins
// - self-powered draw limit in 2mA units
// - bus-powered draw limit in 2mA units
// - controller self-powered current resets to 50
// - remap flag zero standard, one remap
`default_nettype none
module hpc_power_config (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       cfg_wr_in,
	input  wire logic [7:0] cfg_addr_in,
	input  wire logic [7:0] cfg_wdata_in,
	output logic      [7:0] cfg_rdata_out,
	input  wire logic       use_defaults_in,
	input  wire logic [1:0] port_off_straps_in,
	input  wire logic       self_powered_in,
	output logic      [1:0] port_enabled_out,
	output logic      [1:0] active_port_count_out,
	output logic      [1:0] port1_number_out,
	output logic      [1:0] port2_number_out,
	output logic      [7:0] upstream_draw_out,
	output logic      [7:0] controller_current_out,
	output logic            port_remap_enable_out
);
	logic [7:0] bus_powered_port_off_mask_reg;
	logic [7:0] self_powered_port_off_mask_reg;
	logic [7:0] self_powered_draw_limit_reg;
	logic [7:0] bus_powered_draw_limit_reg;
	logic [7:0] controller_self_powered_current_reg;
	logic       port_remap_enable_reg;
	logic [1:0] strap_meta_reg;
	logic [1:0] strap_sync_reg;
	logic       dflt_meta_reg;
	logic [1:0] mode_sync_reg;
	logic       sp_meta_reg;
	logic [1:0] off_next;
	logic [1:0] en_next;
	logic [7:0] rdata_next;

	// straps and mode pins are asynchronous: two flops before use
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			strap_meta_reg <= 2'h0;
			strap_sync_reg <= 2'h0;
			dflt_meta_reg  <= 1'b0;
			sp_meta_reg    <= 1'b0;
			mode_sync_reg  <= 2'h0;
		end else begin
			strap_meta_reg <= port_off_straps_in;
			strap_sync_reg <= strap_meta_reg;
			dflt_meta_reg  <= use_defaults_in;
			sp_meta_reg    <= self_powered_in;
			mode_sync_reg  <= {sp_meta_reg, dflt_meta_reg};
		end
	end

	// loader writes; reserved mask bits are forced so bit 3 stays one, bit 0 zero
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bus_powered_port_off_mask_reg       <= hpc_pkg::RST_PORT_OFF;
			self_powered_port_off_mask_reg      <= hpc_pkg::RST_PORT_OFF;
			self_powered_draw_limit_reg         <= hpc_pkg::RST_DRAW_SP;
			bus_powered_draw_limit_reg          <= hpc_pkg::RST_DRAW_BP;
			controller_self_powered_current_reg <= hpc_pkg::RST_CTRL_CUR_SP;
			port_remap_enable_reg               <=
				hpc_pkg::RST_CFG_BYTE3[hpc_pkg::BIT_REMAP_EN];
		end else if (cfg_wr_in) begin
			case (cfg_addr_in)
				hpc_pkg::OFF_PORT_OFF_BP: bus_powered_port_off_mask_reg <=
					(cfg_wdata_in & hpc_pkg::MASK_WRITABLE) | hpc_pkg::MASK_FIXED_ONES;
				hpc_pkg::OFF_PORT_OFF_SP: self_powered_port_off_mask_reg <=
					(cfg_wdata_in & hpc_pkg::MASK_WRITABLE) | hpc_pkg::MASK_FIXED_ONES;
				hpc_pkg::OFF_DRAW_SP:     self_powered_draw_limit_reg <= cfg_wdata_in;
				hpc_pkg::OFF_DRAW_BP:     bus_powered_draw_limit_reg <= cfg_wdata_in;
				hpc_pkg::OFF_CTRL_CUR_SP: controller_self_powered_current_reg <= cfg_wdata_in;
				hpc_pkg::OFF_CFG_BYTE3:   port_remap_enable_reg <=
					cfg_wdata_in[hpc_pkg::BIT_REMAP_EN];
				default: ;
			endcase
		end
	end

	// pick the mask: straps under defaults, else by power mode; remap mode leaves all on
	always_comb begin
		if (mode_sync_reg[0])
			off_next = strap_sync_reg;
		else if (mode_sync_reg[1])
			off_next = {self_powered_port_off_mask_reg[hpc_pkg::BIT_PORT2],
				self_powered_port_off_mask_reg[hpc_pkg::BIT_PORT1]};
		else
			off_next = {bus_powered_port_off_mask_reg[hpc_pkg::BIT_PORT2],
				bus_powered_port_off_mask_reg[hpc_pkg::BIT_PORT1]};
		// remap tables live elsewhere; here remap mode simply does not apply the mask
		en_next = port_remap_enable_reg ? 2'h3 : ~off_next;
	end

	// enables, compacted numbering and power reports are registered outputs
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			port_enabled_out       <= 2'h0;
			active_port_count_out  <= 2'h0;
			port1_number_out       <= 2'h0;
			port2_number_out       <= 2'h0;
			upstream_draw_out      <= 8'h00;
			controller_current_out <= 8'h00;
			port_remap_enable_out  <= 1'b0;
		end else begin
			port_enabled_out      <= en_next;
			active_port_count_out <= {1'b0, en_next[0]} + {1'b0, en_next[1]};
			port1_number_out      <= en_next[0] ? 2'h1 : 2'h0;
			port2_number_out      <= en_next[1] ? (en_next[0] ? 2'h2 : 2'h1) : 2'h0;
			upstream_draw_out     <= mode_sync_reg[1] ? self_powered_draw_limit_reg
				: bus_powered_draw_limit_reg;
			controller_current_out <= controller_self_powered_current_reg;
			port_remap_enable_out  <= port_remap_enable_reg;
		end
	end

	// read-back mux, unmapped offsets read zero
	always_comb begin
		case (cfg_addr_in)
			hpc_pkg::OFF_PORT_OFF_BP: rdata_next = bus_powered_port_off_mask_reg;
			hpc_pkg::OFF_PORT_OFF_SP: rdata_next = self_powered_port_off_mask_reg;
			hpc_pkg::OFF_DRAW_SP:     rdata_next = self_powered_draw_limit_reg;
			hpc_pkg::OFF_DRAW_BP:     rdata_next = bus_powered_draw_limit_reg;
			hpc_pkg::OFF_CTRL_CUR_SP: rdata_next = controller_self_powered_current_reg;
			hpc_pkg::OFF_CFG_BYTE3:   rdata_next = {4'h0, port_remap_enable_reg, 3'h0};
			default:                  rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			cfg_rdata_out <= 8'h00;
		else
			cfg_rdata_out <= rdata_next;
	end

	property p_mask_fixed;
		@(posedge clk_in) disable iff (!nrst_in)
		bus_powered_port_off_mask_reg[hpc_pkg::BIT_RSVD_ONE] &&
		!bus_powered_port_off_mask_reg[hpc_pkg::BIT_RSVD_ZERO];
	endproperty
	a_mask_fixed: assert property (p_mask_fixed) else $error("reserved mask bits wrong");

	property p_masked_off;
		@(posedge clk_in) disable iff (!nrst_in)
		(!port_remap_enable_reg && !mode_sync_reg[0] && !mode_sync_reg[1] &&
		bus_powered_port_off_mask_reg[hpc_pkg::BIT_PORT1]) |=> !port_enabled_out[0];
	endproperty
	a_masked_off: assert property (p_masked_off) else $error("masked port enabled");

	property p_count;
		@(posedge clk_in) disable iff (!nrst_in)
		active_port_count_out == ({1'b0, port_enabled_out[0]} + {1'b0, port_enabled_out[1]});
	endproperty
	a_count: assert property (p_count) else $error("active count wrong");

	property p_renumber;
		@(posedge clk_in) disable iff (!nrst_in)
		(port_enabled_out == 2'h2) |-> (port2_number_out == 2'h1);
	endproperty
	a_renumber: assert property (p_renumber) else $error("port not compacted");

	property p_straps;
		@(posedge clk_in) disable iff (!nrst_in)
		(mode_sync_reg[0] && !port_remap_enable_reg) |=>
		(port_enabled_out == ~$past(strap_sync_reg));
	endproperty
	a_straps: assert property (p_straps) else $error("straps ignored");

	property p_draw_sp;
		@(posedge clk_in) disable iff (!nrst_in)
		mode_sync_reg[1] |=> (upstream_draw_out == $past(self_powered_draw_limit_reg));
	endproperty
	a_draw_sp: assert property (p_draw_sp) else $error("self draw not used");

	property p_draw_bp;
		@(posedge clk_in) disable iff (!nrst_in)
		!mode_sync_reg[1] |=> (upstream_draw_out == $past(bus_powered_draw_limit_reg));
	endproperty
	a_draw_bp: assert property (p_draw_bp) else $error("bus draw not used");

	property p_cur_reset;
		@(posedge clk_in) disable iff (!nrst_in)
		$rose(nrst_in) |-> (controller_self_powered_current_reg == hpc_pkg::RST_CTRL_CUR_SP);
	endproperty
	a_cur_reset: assert property (p_cur_reset) else $error("current default wrong");

	property p_remap;
		@(posedge clk_in) disable iff (!nrst_in)
		(cfg_wr_in && cfg_addr_in == hpc_pkg::OFF_CFG_BYTE3) |=>
		(port_remap_enable_reg == $past(cfg_wdata_in[hpc_pkg::BIT_REMAP_EN]));
	endproperty
	a_remap: assert property (p_remap) else $error("remap flag not stored");

	// port 2 mask bit must keep port 2 off in standard numbering
	property p_masked_off2;
		@(posedge clk_in) disable iff (!nrst_in)
		(!port_remap_enable_reg && !mode_sync_reg[0] && !mode_sync_reg[1] &&
		bus_powered_port_off_mask_reg[hpc_pkg::BIT_PORT2]) |=> !port_enabled_out[1];
	endproperty
	a_masked_off2: assert property (p_masked_off2) else $error("masked port 2 enabled");

	// remap mode bypasses the mask: without remap tables every port stays on
	property p_remap_all;
		@(posedge clk_in) disable iff (!nrst_in)
		port_remap_enable_reg |=> (port_enabled_out == 2'h3);
	endproperty
	a_remap_all: assert property (p_remap_all) else $error("remap mode masked a port");

	// a lone port 1 keeps number one and port 2 reports no number
	property p_number_one;
		@(posedge clk_in) disable iff (!nrst_in)
		(port_enabled_out == 2'h1) |-> (port1_number_out == 2'h1 && port2_number_out == 2'h0);
	endproperty
	a_number_one: assert property (p_number_one) else $error("lone port misnumbered");
endmodule
`default_nettype wire

// ### bench/hpc_loader.sv
// loader model: the configuration source that writes and addresses the bank
`default_nettype none
module hpc_loader (
	input  wire logic       clk_in,
	output var  logic       cfg_wr_out,
	output var  logic [7:0] cfg_addr_out,
	output var  logic [7:0] cfg_wdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cfg_wr_out = 1'b0;
		cfg_addr_out = 8'h00;
		cfg_wdata_out = 8'h00;
	end
	// one byte per strobe; bytes are passed whole, in 2mA counts
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		cfg_wr_out = 1'b1;
		cfg_addr_out = a;
		cfg_wdata_out = d;
		@(negedge clk_in);
		cfg_wr_out = 1'b0;
		cfg_wdata_out = ~d; // released data must not look like the last byte
	endtask
	// read data is registered, so allow one edge after the address
	task automatic look(input logic [7:0] a);
		@(negedge clk_in);
		cfg_addr_out = a;
		@(negedge clk_in);
	endtask
endmodule
`default_nettype wire

// ### bench/hpc_power_config_test.sv
// self-checking bench of the hub power configuration bank
`default_nettype none
module hpc_power_config_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in, nrst_in, cfg_wr_in, use_defaults_in, self_powered_in;
	logic        port_remap_enable_out;
	logic [7:0]  cfg_addr_in, cfg_wdata_in, cfg_rdata_out, upstream_draw_out;
	logic [7:0]  controller_current_out;
	logic [1:0]  port_off_straps_in, port_enabled_out, active_port_count_out;
	logic [1:0]  port1_number_out, port2_number_out;
	int          n_mismatch = 0;
	int          n_checks = 0;
	// row: mask byte written, mask read back, {enabled, count, port1 no, port2 no}
	logic [23:0] rows [5] = '{24'h00_08_e6, 24'h02_0a_91, 24'h04_0c_54, 24'hff_0e_00,
		24'h01_08_e6};
	logic [15:0] rv [4] = '{{hpc_pkg::OFF_PORT_OFF_BP, hpc_pkg::RST_PORT_OFF},
		{hpc_pkg::OFF_DRAW_SP, hpc_pkg::RST_DRAW_SP}, {hpc_pkg::OFF_DRAW_BP, hpc_pkg::RST_DRAW_BP},
		{hpc_pkg::OFF_CTRL_CUR_SP, hpc_pkg::RST_CTRL_CUR_SP}};
	hpc_loader hpc_loader_i (.clk_in, .cfg_wr_out(cfg_wr_in), .cfg_addr_out(cfg_addr_in),
		.cfg_wdata_out(cfg_wdata_in));
	hpc_power_config hpc_power_config_i (.clk_in, .nrst_in, .cfg_wr_in, .cfg_addr_in,
		.cfg_wdata_in, .cfg_rdata_out, .use_defaults_in, .port_off_straps_in,
		.self_powered_in, .port_enabled_out, .active_port_count_out, .port1_number_out,
		.port2_number_out, .upstream_draw_out, .controller_current_out,
		.port_remap_enable_out);
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ports(input logic [7:0] e);
		chk("ports", e, {port_enabled_out, active_port_count_out, port1_number_out,
			port2_number_out});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// pins are synchronised, so pin changes are checked four cycles on
	initial begin
		nrst_in = 1'b0;
		use_defaults_in = 1'b0;
		self_powered_in = 1'b0;
		port_off_straps_in = 2'h0;
		tick(4);
		nrst_in = 1'b1;
		tick(4);
		ports(8'he6);
		foreach (rows[i]) begin
			hpc_loader_i.put(8'h0b, rows[i][23:16]);
			hpc_loader_i.look(8'h0b);
			chk("mask", rows[i][15:8], cfg_rdata_out);
			ports(rows[i][7:0]);
		end
		$display("mask table done");
		hpc_loader_i.put(8'h0b, 8'h06);
		hpc_loader_i.put(8'h0c, 8'h19);
		hpc_loader_i.put(8'h0d, 8'h64);
		tick(1);
		chk("draw_bp", 8'h64, upstream_draw_out);
		self_powered_in = 1'b1;
		tick(4);
		chk("draw_sp", 8'h19, upstream_draw_out);
		ports(8'he6);
		self_powered_in = 1'b0;
		tick(4);
		ports(8'h00);
		hpc_loader_i.put(8'h0e, 8'h20);
		tick(1);
		chk("ctrl_cur", 8'h20, controller_current_out);
		$display("power modes done");
		use_defaults_in = 1'b1;
		port_off_straps_in = 2'b01;
		tick(4);
		ports(8'h91);
		port_off_straps_in = 2'b10;
		tick(4);
		ports(8'h54);
		use_defaults_in = 1'b0;
		hpc_loader_i.put(8'h08, 8'h08);
		tick(1);
		chk("remap", 8'h01, {7'h00, port_remap_enable_out});
		ports(8'he6);
		hpc_loader_i.put(8'h08, 8'h00);
		tick(1);
		chk("remap", 8'h00, {7'h00, port_remap_enable_out});
		ports(8'h00);
		hpc_loader_i.put(8'h20, 8'h5a);
		hpc_loader_i.look(8'h20);
		chk("unmapped", 8'h00, cfg_rdata_out);
		hpc_loader_i.look(8'h0d);
		chk("unmapped_alias", 8'h64, cfg_rdata_out);
		$display("defaults, remap and unmapped done");
		nrst_in = 1'b0;
		tick(1);
		chk("draw_rst", 8'h00, upstream_draw_out);
		nrst_in = 1'b1;
		tick(4);
		chk("ctrl_cur", hpc_pkg::RST_CTRL_CUR_SP, controller_current_out);
		foreach (rv[i]) begin
			hpc_loader_i.look(rv[i][15:8]);
			chk("reset_val", rv[i][7:0], cfg_rdata_out);
		end
		$display("reset done");
		conclude();
	end
	// a run that overstays its bound is a failure
	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
